// *** rtl/asps_device.sv ***
// device end: serial port sequencer, select filter and conversion step counter
`timescale 1ns/1ps
module asps_device
	import asps_pkg::*;
#(
	parameter bit INTERNAL_OSC = 1'b0
)(
	input wire logic sys_clk,
	input wire logic rst,
	asps_link_if.dev link,
	input wire logic [RES_W-1:0] analog_code,
	output logic [ADDR_W-1:0] sample_channel,
	output logic sampling,
	output logic busy
);
	asps_dev_state_t st;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] prev;
	logic cs_acc;
	logic [8:0] filt_cnt;
	logic [7:0] osc_cnt;
	logic [4:0] fall_cnt;
	logic [4:0] rise_cnt;
	logic rise_after10;
	logic [5:0] step_cnt;
	logic [ADDR_W-1:0] addr;
	logic [RES_W-1:0] shreg;
	logic [RES_W-1:0] held;
	logic [RES_W-1:0] result;
	logic dout;
	logic dout_oe;
	logic done;

	assign link.serial_result_out = dout;
	assign link.serial_result_oe = dout_oe;
	assign link.conversion_done_flag = done;

	// edge detectors compare the second stage with prev, the stage after it
	wire cs_lvl = sync2[3];
	wire din_lvl = sync2[1];
	wire sclk_rise = sync2[2] && !prev[2];
	wire sclk_fall = !sync2[2] && prev[2];
	wire cclk_fall = !sync2[0] && prev[0];
	wire osc_tick = (osc_cnt == 8'(OSC_STEP_CYC - 1));
	wire step_tick = INTERNAL_OSC ? osc_tick : cclk_fall;

	// level must persist before it counts
	wire filt_inc = INTERNAL_OSC ? 1'b1 : cclk_fall;
	wire [8:0] filt_last = INTERNAL_OSC ? 9'(CS_FILT_CYC - 1) : CS_FILT_EDGES - 1'b1;
	wire cs_diff = (cs_lvl != cs_acc);
	wire cs_accept = cs_diff && filt_inc && (filt_cnt == filt_last);
	wire cs_fall_ok = cs_accept && cs_acc;
	wire cs_rise_ok = cs_accept && !cs_acc;

	// serial clock and address ignored while deselected
	wire sf = sclk_fall && !cs_acc;
	wire sr = sclk_rise && !cs_acc;

	// fixed step count ends the conversion
	wire conv_end = (st == DEV_CONV) && step_tick && (step_cnt == CONV_STEPS - 1'b1);
	wire tenth_fall = (st == DEV_SHIFT) && sf && (fall_cnt == XFER_SHORT - 1'b1);

	// restart on conversion end or on the 16th fall
	// no rise after the tenth means a ten-clock frame
	wire restart_conv = conv_end && !cs_acc && (!rise_after10 || fall_cnt >= XFER_LONG);
	wire restart_tail = (st == DEV_TAIL) && sf && (fall_cnt == XFER_LONG - 1'b1);
	wire start = cs_fall_ok || restart_conv || restart_tail;
	wire [RES_W-1:0] load_val = conv_end ? held : result;

	// test addresses replace the input; E and F pass it through
	wire [RES_W-1:0] conv_code =
		(addr == ADDR_TEST_HALF) ? CODE_HALF :
		(addr == ADDR_TEST_ZERO) ? CODE_ZERO :
		(addr == ADDR_TEST_FULL) ? CODE_FULL : analog_code;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			// idle pin levels: select high, clocks and address low, so no false edge after reset
			sync1 <= 4'h8;
			sync2 <= 4'h8;
			prev <= 4'h8;
		end
		else
		begin
			sync1 <= {link.chip_select_n, link.serial_shift_clock, link.serial_address_in, link.conversion_clock};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cs_acc <= 1'b1;
			filt_cnt <= '0;
			dout_oe <= 1'b0;
			osc_cnt <= '0;
		end
		else
		begin
			osc_cnt <= osc_tick ? '0 : osc_cnt + 1'b1;
			if (!cs_diff || cs_accept)
				filt_cnt <= '0;
			else if (filt_inc)
				filt_cnt <= filt_cnt + 1'b1;
			if (cs_accept)
			begin
				cs_acc <= cs_lvl;
				dout_oe <= cs_acc;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= DEV_IDLE;
			fall_cnt <= '0;
			rise_cnt <= '0;
			rise_after10 <= 1'b0;
			step_cnt <= '0;
			addr <= '0;
			shreg <= '0;
			held <= '0;
			result <= RESULT_RST;
			dout <= 1'b0;
			done <= 1'b1;
			sampling <= 1'b0;
			sample_channel <= '0;
		end
		else
		begin
			if (step_tick && st == DEV_CONV)
				step_cnt <= step_cnt + 1'b1;
			// writing the result is the final step
			if (conv_end)
			begin
				result <= held;
				done <= 1'b1;
			end
			if (start)
			begin
				// reset the port, show old MSB, keep result
				st <= DEV_SHIFT;
				fall_cnt <= '0;
				rise_cnt <= '0;
				dout <= load_val[RES_W-1];
				shreg <= {load_val[RES_W-2:0], 1'b0};
				sampling <= 1'b0;
			end
			else if (cs_rise_ok && st != DEV_CONV)
			begin
				st <= DEV_IDLE;
				sampling <= 1'b0;
			end
			else
			begin
				if (conv_end)
					st <= cs_acc ? DEV_IDLE : DEV_TAIL;
				// first four rises shift the address in
				if (sr && st == DEV_SHIFT && rise_cnt < ADDR_RISES)
					addr <= {addr[ADDR_W-2:0], din_lvl};
				if (sr && st != DEV_IDLE && rise_cnt != CNT_MAX)
					rise_cnt <= rise_cnt + 1'b1;
				// a rise during conversion marks a long frame
				if (sr && st == DEV_CONV)
					rise_after10 <= 1'b1;
				if (sf && st != DEV_IDLE)
				begin
					if (fall_cnt != CNT_MAX)
						fall_cnt <= fall_cnt + 1'b1;
					// zeros follow the LSB; no timing on the clock
					dout <= shreg[RES_W-1];
					shreg <= {shreg[RES_W-2:0], 1'b0};
				end
				if (sf && st == DEV_SHIFT && fall_cnt == SAMPLE_FALL - 1'b1)
				begin
					sampling <= 1'b1;
					sample_channel <= addr;
				end
				if (tenth_fall)
				begin
					// hold and hand over to the step counter
					sampling <= 1'b0;
					held <= conv_code;
					st <= DEV_CONV;
					step_cnt <= '0;
					rise_after10 <= 1'b0;
					// done drops at the tenth fall
					done <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= (st == DEV_CONV) && !conv_end && !cs_fall_ok;
	end
endmodule

// *** rtl/asps_pkg.sv ***
// shared constants and types for the serial converter port and its host
package asps_pkg;
	localparam int SYS_CLK_NS = 4;
	localparam int RES_W = 10;
	localparam int ADDR_W = 4;
	localparam logic [4:0] XFER_SHORT = 5'h0a;
	localparam logic [4:0] XFER_LONG = 5'h10;
	localparam logic [4:0] ADDR_RISES = 5'h04;
	localparam logic [4:0] SAMPLE_FALL = 5'h04;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	localparam logic [5:0] CONV_STEPS = 6'h2c;
	localparam logic [8:0] CS_FILT_EDGES = 9'h002;
	localparam int CS_FILT_NS = 2000;
	localparam int CS_FILT_CYC = (CS_FILT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int OSC_STEP_NS = 1000;
	localparam int OSC_STEP_CYC = OSC_STEP_NS / SYS_CLK_NS;
	localparam int SCLK_HALF_NS = 190;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int CS_SETUP_NS = 2425;
	localparam int CS_SETUP_CYC = (CS_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS + 4 * SCLK_HALF_CYC;
	localparam int CS_HOLD_CYC = CS_FILT_CYC + 4 * SCLK_HALF_CYC;
	localparam logic [3:0] ADDR_TEST_HALF = 4'hb;
	localparam logic [3:0] ADDR_TEST_ZERO = 4'hc;
	localparam logic [3:0] ADDR_TEST_FULL = 4'hd;
	localparam logic [9:0] CODE_HALF = 10'h200;
	localparam logic [9:0] CODE_ZERO = 10'h000;
	localparam logic [9:0] CODE_FULL = 10'h3ff;
	localparam logic [9:0] RESULT_RST = 10'h000;
	typedef enum logic [1:0] {DEV_IDLE, DEV_SHIFT, DEV_CONV, DEV_TAIL} asps_dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_WAIT} asps_host_state_t;
endpackage

// *** rtl/asps_link_if.sv ***
// serial link between the converter port and its host
`timescale 1ns/1ps
interface asps_link_if;
	logic chip_select_n;
	logic serial_shift_clock;
	logic serial_address_in;
	logic serial_result_out;
	logic serial_result_oe;
	logic conversion_clock;
	logic conversion_done_flag;
	modport dev
	(
		input chip_select_n,
		input serial_shift_clock,
		input serial_address_in,
		input conversion_clock,
		output serial_result_out,
		output serial_result_oe,
		output conversion_done_flag
	);
	modport hst
	(
		output chip_select_n,
		output serial_shift_clock,
		output serial_address_in,
		output conversion_clock,
		input serial_result_out,
		input conversion_done_flag
	);
endinterface

// *** rtl/asps_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module asps_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge sys_clk)
	begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end
endmodule

// *** rtl/asps_host.sv ***
// host end: drives select, serial clock, address and the free-running conversion clock
`timescale 1ns/1ps
module asps_host
	import asps_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
)(
	input wire logic sys_clk,
	input wire logic rst,
	asps_link_if.hst link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic cmd_long,
	output logic res_valid,
	input wire logic res_ready,
	output logic [RES_W-1:0] res_data
);
	asps_host_state_t st;
	logic [9:0] tmr;
	logic [7:0] cclk_div;
	logic cclk;
	logic cs_n;
	logic sclk;
	logic din;
	logic [4:0] nfall;
	logic [4:0] nbits;
	logic [ADDR_W-1:0] addr;
	logic [RES_W-1:0] rx;
	logic push;
	logic [1:0] dout_s;
	logic [1:0] done_s;
	logic fifo_in_ready;

	wire half_done = (tmr == 10'(SCLK_HALF_CYC - 1));
	// next address bit goes out on this fall, ready for the following rise
	wire next_din = (nfall + 1'b1 < ADDR_RISES) ? addr[2'd2 - nfall[1:0]] : 1'b0;

	assign link.chip_select_n = cs_n;
	assign link.serial_shift_clock = sclk;
	assign link.serial_address_in = din;
	assign link.conversion_clock = cclk;

	// conversion clock must run free, so it never stops between frames
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cclk_div <= '0;
			cclk <= 1'b0;
		end
		else if (cclk_div == 8'(SCLK_HALF_CYC - 1))
		begin
			cclk_div <= '0;
			cclk <= !cclk;
		end
		else
			cclk_div <= cclk_div + 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			dout_s <= '0;
			done_s <= '0;
		end
		else
		begin
			dout_s <= {dout_s[0], link.serial_result_out};
			done_s <= {done_s[0], link.conversion_done_flag};
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= H_IDLE;
			tmr <= '0;
			cs_n <= 1'b1;
			sclk <= 1'b0;
			din <= 1'b0;
			nfall <= '0;
			nbits <= XFER_SHORT;
			addr <= '0;
			rx <= '0;
			push <= 1'b0;
			cmd_ready <= 1'b0;
		end
		else
		begin
			push <= 1'b0;
			tmr <= tmr + 1'b1;
			cmd_ready <= (st == H_IDLE) && fifo_in_ready && !(cmd_valid && cmd_ready);
			case (st)
				H_IDLE:
					if (cmd_valid && cmd_ready)
					begin
						cs_n <= 1'b0;
						addr <= cmd_addr;
						nbits <= cmd_long ? XFER_LONG : XFER_SHORT;
						nfall <= '0;
						tmr <= '0;
						st <= H_SETUP;
					end
				H_SETUP:
					if (tmr == 10'(CS_SETUP_CYC - 1))
					begin
						din <= addr[3];
						tmr <= '0;
						st <= H_LOW;
					end
				H_LOW:
					if (half_done)
					begin
						sclk <= 1'b1;
						tmr <= '0;
						st <= H_HIGH;
					end
				H_HIGH:
					if (half_done)
					begin
						// sample just before the fall, long after the device updated
						if (nfall < XFER_SHORT)
							rx <= {rx[RES_W-2:0], dout_s[1]};
						sclk <= 1'b0;
						nfall <= nfall + 1'b1;
						din <= next_din;
						tmr <= '0;
						st <= (nfall == nbits - 1'b1) ? H_END : H_LOW;
					end
				H_END:
				begin
					cs_n <= 1'b1;
					if (tmr == 10'(CS_HOLD_CYC - 1))
					begin
						push <= 1'b1;
						st <= H_WAIT;
					end
				end
				H_WAIT:
					// never reselect before the result is written
					if (done_s[1])
						st <= H_IDLE;
				default:
					st <= H_IDLE;
			endcase
		end
	end

	asps_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(rx),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(res_data)
	);
endmodule

// *** dv/asps_link_monitor.sv ***
// assertion checker watching the serial link between host and device
`timescale 1ns/1ps
module asps_link_monitor
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic serial_shift_clock,
	input wire logic serial_address_in,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic conversion_clock,
	input wire logic conversion_done_flag
);
	logic sclk_q;
	logic cclk_q;
	logic cs_q;
	logic [4:0] falls;
	logic [4:0] fall_age;
	logic [5:0] cc_conv;
	logic [1:0] cc_sel;
	logic [10:0] hi_cnt;
	wire sclk_fall = sclk_q & ~serial_shift_clock;
	wire cclk_fall = cclk_q & ~conversion_clock;
	wire at_tenth = (falls == 5'h0a);
	// fall_age, cc_sel and hi_cnt saturate so a long idle select never wraps into a false trigger
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_q <= 1'b0;
			cclk_q <= 1'b0;
			cs_q <= 1'b1;
			falls <= 5'h00;
			fall_age <= 5'h1f;
			cc_conv <= 6'h00;
			cc_sel <= 2'h0;
			hi_cnt <= 11'h000;
		end
		else
		begin
			sclk_q <= serial_shift_clock;
			cclk_q <= conversion_clock;
			cs_q <= chip_select_n;
			// count kept until the next select fall: the host may deselect right after the last fall
			falls <= (cs_q & ~chip_select_n) ? 5'h00 : falls + {4'h0, sclk_fall & ~chip_select_n};
			fall_age <= sclk_fall ? 5'h00 : fall_age + {4'h0, fall_age != 5'h1f};
			cc_conv <= conversion_done_flag ? 6'h00 : cc_conv + {5'h00, cclk_fall};
			cc_sel <= chip_select_n ? 2'h0 : cc_sel + {1'b0, cclk_fall && cc_sel != 2'h3};
			hi_cnt <= chip_select_n ? hi_cnt + {10'h000, hi_cnt != 11'h7d0} : 11'h000;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_oe_select;
		$rose(serial_result_oe) |-> !chip_select_n && cc_sel >= 2'h2;
	endproperty
	a_oe_select: assert property (p_oe_select)
		else $error("output driven before select was confirmed");
	property p_release;
		hi_cnt == 11'h7d0 |-> !serial_result_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("output still driven with select high");
	property p_tenth_low;
		$rose(at_tenth) |-> ##6 (!serial_result_out && serial_result_oe);
	endproperty
	a_tenth_low: assert property (p_tenth_low)
		else $error("output not low after tenth fall");
	property p_tail_zero;
		(falls > 5'h0a && falls < 5'h10 && serial_result_oe) |-> !serial_result_out;
	endproperty
	a_tail_zero: assert property (p_tail_zero)
		else $error("extra clocks read a one");
	property p_done_at_tenth;
		$fell(conversion_done_flag) |-> at_tenth && fall_age <= 5'h08;
	endproperty
	a_done_at_tenth: assert property (p_done_at_tenth)
		else $error("done fell away from tenth fall");
	property p_handover;
		$rose(at_tenth) |-> ##[1:8] !conversion_done_flag;
	endproperty
	a_handover: assert property (p_handover)
		else $error("conversion not started at tenth fall");
	property p_conv_len;
		$rose(conversion_done_flag) |-> cc_conv >= 6'h2b && cc_conv <= 6'h2d;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion length not 44 clocks");
	property p_bit_timing;
		$changed(serial_result_out) && serial_result_oe && $past(serial_result_oe) |-> fall_age <= 5'h08;
	endproperty
	a_bit_timing: assert property (p_bit_timing)
		else $error("output bit changed away from a clock fall");
	c_long: cover property (falls == 5'h10);
	c_tenth: cover property ($rose(at_tenth));
	c_done: cover property ($rose(conversion_done_flag));
endmodule

// *** dv/adc_serial_port_sequencer_bench.sv ***
// self-checking bench: host and device ends joined by the serial link
`timescale 1ns/1ps
module adc_serial_port_sequencer_bench
	import asps_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_addr = 4'h0;
	logic cmd_long = 1'b0;
	logic res_ready = 1'b0;
	logic [9:0] analog_code = 10'h000;
	logic cmd_ready, res_valid, sampling, busy;
	logic [3:0] sample_channel;
	logic [9:0] res_data;
	int fail_count = 0;
	int checks = 0;
	logic [3:0] addr_tab [8] = '{4'hb, 4'hc, 4'hd, 4'h3, 4'he, 4'ha, 4'hf, 4'h0};
	logic long_tab [8] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
	logic [9:0] ana_tab [8] = '{10'h155, 10'h2aa, 10'h001, 10'h3fe, 10'h0f0, 10'h30c, 10'h111, 10'h222};
	asps_link_if asps_link_if_i ();
	asps_device asps_device_i (.sys_clk(sys_clk), .rst(rst), .link(asps_link_if_i), .analog_code(analog_code),
		.sample_channel(sample_channel), .sampling(sampling), .busy(busy));
	asps_host asps_host_i (.sys_clk(sys_clk), .rst(rst), .link(asps_link_if_i), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_long(cmd_long), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data));
	asps_link_monitor asps_link_monitor_i (.sys_clk(sys_clk), .rst(rst),
		.chip_select_n(asps_link_if_i.chip_select_n), .serial_shift_clock(asps_link_if_i.serial_shift_clock),
		.serial_address_in(asps_link_if_i.serial_address_in), .serial_result_out(asps_link_if_i.serial_result_out),
		.serial_result_oe(asps_link_if_i.serial_result_oe), .conversion_clock(asps_link_if_i.conversion_clock),
		.conversion_done_flag(asps_link_if_i.conversion_done_flag));
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	function automatic logic [9:0] exp_code(input int i);
		case (addr_tab[i])
			ADDR_TEST_HALF: exp_code = CODE_HALF;
			ADDR_TEST_ZERO: exp_code = CODE_ZERO;
			ADDR_TEST_FULL: exp_code = CODE_FULL;
			default: exp_code = ana_tab[i];
		endcase
	endfunction
	function automatic bit cond(input int which);
		case (which)
			0: cond = cmd_ready === 1'b1;
			1: cond = asps_link_if_i.chip_select_n === 1'b0;
			2: cond = asps_link_if_i.chip_select_n === 1'b1;
			3: cond = res_valid === 1'b1;
			5: cond = sampling === 1'b1;
			default: cond = asps_link_if_i.conversion_done_flag === 1'b1;
		endcase
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a frame plus its conversion stays well inside this bound
	task automatic wait_for(input int which);
		int n;
		n = 0;
		while (!cond(which))
		begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 9000)
			begin
				fail_count++;
				$display("Error wait %0d expected 1 seen 0", which);
				give_verdict();
			end
		end
	endtask
	task automatic issue(input int i);
		wait_for(0);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_addr <= addr_tab[i];
		cmd_long <= long_tab[i];
		analog_code <= ana_tab[i];
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
		wait_for(1);
		wait_for(5);
		check("open channel", {6'h00, addr_tab[i]}, {6'h00, sample_channel});
		wait_for(2);
		// select may rise right after the tenth fall; give the device its input latency
		repeat (8) @(posedge sys_clk);
		#1;
		check("channel", {6'h00, addr_tab[i]}, {6'h00, sample_channel});
		check("sampling", 10'h000, {9'h000, sampling});
		check("busy", 10'h001, {9'h000, busy});
		check("done", 10'h000, {9'h000, asps_link_if_i.conversion_done_flag});
	endtask
	// the first word after power-up is RESULT_RST, not a conversion, so index -1 skips the compare
	task automatic pop(input int i);
		wait_for(3);
		if (i >= 0)
			check("result", exp_code(i), res_data);
		@(posedge sys_clk);
		res_ready <= 1'b1;
		@(posedge sys_clk);
		res_ready <= 1'b0;
		#1;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		for (int i = 0; i < 4; i++)
			issue(i);
		wait_for(4);
		repeat (40) @(posedge sys_clk);
		#1;
		check("full ready", 10'h000, {9'h000, cmd_ready});
		check("full valid", 10'h001, {9'h000, res_valid});
		$display("fill test done");
		for (int i = -1; i < 3; i++)
			pop(i);
		check("empty", 10'h000, {9'h000, res_valid});
		$display("drain test done");
		for (int i = 4; i < 8; i++)
		begin
			issue(i);
			pop(i - 1);
		end
		$display("stream test done");
		give_verdict();
	end
endmodule
